//--- rtl/tws_slave.sv
`timescale 1ns/10ps
// Function
// - START clears collision flag; repeated START leaves it set.
// - Same-cycle clear and set of addr_stop_irq_flag keeps SCL held.
// - Timeout coinciding with START detection abandons the transaction.
// - Command 0b11 clears byte_irq_flag one cycle late.
module tws_slave #(
    parameter int TMO_CYC = tws_pkg::TMO_CYCLES
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Two-wire bus
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    // Interrupt
    output logic             irq
);
    typedef struct packed {
        tws_pkg::tws_st_t st;
        logic [2:0]  ctrl;
        logic [6:0]  addr;
        logic        addr_stop_irq_flag;
        logic        byte_irq_flag;
        logic        dif_clr_pend;
        logic        coll;
        logic        scl_stretch_hold;
        logic        dir_rd;
        logic        is_addr;
        logic        busy;
        logic [3:0]  bitcnt;
        logic [7:0]  shreg;
        logic [7:0]  txd;
        logic [7:0]  rxd;
        logic        ack_ok;
        logic        sda_low;
        logic [15:0] tmo;
        logic [4:0]  ev_sts;
        logic [4:0]  ev_en;
        logic [31:0] rdata;
    } tws_state_t;

    tws_state_t        q;
    tws_state_t        d;
    tws_pkg::tws_line_t ln;
    logic              acc;
    logic              wr;
    logic              sw_clr_addr_stop_irq_flag;
    logic              hw_set_addr_stop_irq_flag;
    logic              tmo_fire;
    logic [4:0]        ev;

    tws_line_mon u_mon (
        .pclk    (pclk),
        .presetn (presetn),
        .scl_i   (scl_i),
        .sda_i   (sda_i),
        .ev      (ln)
    );

    assign acc     = psel & penable;
    assign wr      = acc & pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign prdata  = q.rdata;
    assign scl_o   = 1'b0;
    assign scl_oe  = q.scl_stretch_hold;
    assign sda_o   = 1'b0;
    assign sda_oe  = q.sda_low;
    assign irq     = |(q.ev_sts & q.ev_en);

    assign sw_clr_addr_stop_irq_flag = wr && paddr == tws_pkg::STATUS_OFS
                         && pwdata[tws_pkg::ST_ASIF_BIT];
    assign tmo_fire    = q.ctrl[tws_pkg::CTRL_TMO_EN_BIT] && q.busy
                         && q.tmo == 16'(TMO_CYC);

    always_comb begin
        d = q;
        ev = '0;
        hw_set_addr_stop_irq_flag = 1'b0;
        // Register writes
        if (wr) begin
            unique case (paddr)
                tws_pkg::CTRL_OFS:    d.ctrl = pwdata[2:0];
                tws_pkg::ADDR_OFS:    d.addr = pwdata[6:0];
                tws_pkg::TXDATA_OFS:  d.txd  = pwdata[7:0];
                tws_pkg::IRQ_EN_OFS:  d.ev_en = pwdata[4:0];
                tws_pkg::IRQ_CLR_OFS: d.ev_sts = q.ev_sts & ~pwdata[4:0];
                tws_pkg::STATUS_OFS: begin
                    if (pwdata[tws_pkg::ST_COLL_BIT])
                        d.coll = 1'b0;
                    if (pwdata[tws_pkg::ST_BIF_BIT])
                        d.byte_irq_flag = 1'b0;
                end
                tws_pkg::CMD_OFS: begin
                    if (pwdata[1:0] == tws_pkg::CMD_RESP_COMPLETE) begin
                        d.dif_clr_pend = 1'b1;
                        d.scl_stretch_hold = 1'b0;
                        d.st = tws_pkg::TWS_SKIP;
                    end else if (pwdata[1:0] == tws_pkg::CMD_RESP_RESPOND) begin
                        d.byte_irq_flag = 1'b0;
                        d.scl_stretch_hold = 1'b0;
                        d.shreg = q.txd;
                    end
                end
                default: ;
            endcase
        end
        // Delayed clear of the byte flag, one cycle after the command
        if (q.dif_clr_pend) begin
            d.byte_irq_flag = 1'b0;
            d.dif_clr_pend  = 1'b0;
        end
        // Clear of the addr/stop flag also releases the clock hold
        if (sw_clr_addr_stop_irq_flag) begin
            d.addr_stop_irq_flag = 1'b0;
            d.scl_stretch_hold   = 1'b0;
        end
        // Bus timeout counter
        d.tmo = (ln.rise || ln.fall || !q.busy) ? 16'h0000
              : (tmo_fire ? q.tmo : q.tmo + 16'h0001);
        if (ln.start) begin
            d.busy = 1'b1;
            d.bitcnt = 4'h0;
            d.sda_low = 1'b0;
            d.st = tws_pkg::TWS_ADDR;
            if (!q.busy)
                d.coll = 1'b0;
            if (tmo_fire && q.ctrl[tws_pkg::CTRL_QUIRK_BIT]) begin
                d.st = tws_pkg::TWS_IDLE;
                d.busy = 1'b0;
                ev[tws_pkg::EV_DROP_BIT] = 1'b1;
            end
        end else if (ln.stop) begin
            d.busy = 1'b0;
            d.sda_low = 1'b0;
            if (q.st != tws_pkg::TWS_IDLE && q.st != tws_pkg::TWS_SKIP) begin
                d.addr_stop_irq_flag = 1'b1;
                ev[tws_pkg::EV_STOP_BIT] = 1'b1;
            end
            d.st = tws_pkg::TWS_IDLE;
        end else if (tmo_fire) begin
            d.busy = 1'b0;
            d.sda_low = 1'b0;
            d.st = tws_pkg::TWS_IDLE;
            ev[tws_pkg::EV_DROP_BIT] = 1'b1;
        end else if (q.ctrl[tws_pkg::CTRL_EN_BIT]) begin
            unique case (q.st)
                tws_pkg::TWS_IDLE: ;
                // Let go of the acknowledge once its clock has ended
                tws_pkg::TWS_SKIP: begin
                    if (ln.fall)
                        d.sda_low = 1'b0;
                end
                tws_pkg::TWS_ADDR, tws_pkg::TWS_RX: begin
                    if (ln.rise) begin
                        d.shreg = {q.shreg[6:0], ln.sda};
                        d.bitcnt = q.bitcnt + 4'h1;
                    end
                    if (ln.fall && q.bitcnt == 4'h8) begin
                        d.bitcnt = 4'h0;
                        if (q.st == tws_pkg::TWS_ADDR) begin
                            if (q.shreg[7:1] == q.addr) begin
                                hw_set_addr_stop_irq_flag = 1'b1;
                                d.is_addr = 1'b1;
                                d.dir_rd = q.shreg[0];
                                d.sda_low = 1'b1;
                                d.scl_stretch_hold = 1'b1;
                                d.st = tws_pkg::TWS_ACK;
                                ev[tws_pkg::EV_ADDR_BIT] = 1'b1;
                                // Lost release: clear collides with set
                                if (sw_clr_addr_stop_irq_flag)
                                    d.scl_stretch_hold = 1'b1;
                            end else begin
                                d.st = tws_pkg::TWS_SKIP;
                            end
                        end else begin
                            d.rxd = q.shreg;
                            d.is_addr = 1'b0;
                            d.byte_irq_flag = 1'b1;
                            d.sda_low = 1'b1;
                            d.scl_stretch_hold = 1'b1;
                            d.st = tws_pkg::TWS_ACK;
                            ev[tws_pkg::EV_BYTE_BIT] = 1'b1;
                        end
                    end
                end
                tws_pkg::TWS_ACK: begin
                    if (ln.fall) begin
                        d.sda_low = q.dir_rd ? ~q.shreg[7] : 1'b0;
                        d.st = q.dir_rd ? tws_pkg::TWS_TX : tws_pkg::TWS_RX;
                        d.bitcnt = 4'h0;
                    end
                end
                tws_pkg::TWS_TX: begin
                    if (ln.rise) begin
                        d.bitcnt = q.bitcnt + 4'h1;
                        if (q.bitcnt < 4'h8 && q.shreg[7] && !ln.sda) begin
                            d.coll = 1'b1;
                            ev[tws_pkg::EV_COLL_BIT] = 1'b1;
                        end
                        if (q.bitcnt == 4'h8)
                            d.ack_ok = ~ln.sda;
                    end
                    if (ln.fall) begin
                        if (q.bitcnt < 4'h8) begin
                            d.shreg = {q.shreg[6:0], 1'b1};
                            d.sda_low = (q.bitcnt == 4'h7) ? 1'b0 : ~q.shreg[6];
                        end else begin
                            d.byte_irq_flag = 1'b1;
                            d.scl_stretch_hold = 1'b1;
                            d.sda_low = 1'b0;
                            d.st = q.ack_ok ? tws_pkg::TWS_ACK : tws_pkg::TWS_SKIP;
                            ev[tws_pkg::EV_BYTE_BIT] = 1'b1;
                        end
                    end
                end
                default: d.st = tws_pkg::TWS_IDLE;
            endcase
        end
        // Hardware set wins over a software clear
        if (hw_set_addr_stop_irq_flag)
            d.addr_stop_irq_flag = 1'b1;
        d.ev_sts = d.ev_sts | ev;
        // Read data
        d.rdata = '0;
        if (acc && !pwrite) begin
            unique case (paddr)
                tws_pkg::CTRL_OFS:     d.rdata[2:0] = q.ctrl;
                tws_pkg::ADDR_OFS:     d.rdata[6:0] = q.addr;
                tws_pkg::TXDATA_OFS:   d.rdata[7:0] = q.txd;
                tws_pkg::RXDATA_OFS:   d.rdata[7:0] = q.rxd;
                tws_pkg::IRQ_STAT_OFS: d.rdata[4:0] = q.ev_sts;
                tws_pkg::IRQ_EN_OFS:   d.rdata[4:0] = q.ev_en;
                tws_pkg::STATUS_OFS:   d.rdata[6:0] = {q.busy, q.is_addr, q.dir_rd,
                                           q.scl_stretch_hold, q.coll,
                                           q.byte_irq_flag, q.addr_stop_irq_flag};
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.ctrl <= tws_pkg::CTRL_RST;
            q.addr <= tws_pkg::ADDR_RST;
            q.st <= tws_pkg::TWS_IDLE;
        end else begin
            q <= d;
        end
    end

    a_coll_restart: assert property (@(posedge pclk) disable iff (!presetn)
        ln.start && q.busy && q.coll |=> q.coll)
        else $error("collision flag cleared on repeated start");
    a_coll_start: assert property (@(posedge pclk) disable iff (!presetn)
        ln.start && !q.busy |=> !q.coll)
        else $error("collision flag kept on start");
    a_hold_lock: assert property (@(posedge pclk) disable iff (!presetn)
        hw_set_addr_stop_irq_flag && sw_clr_addr_stop_irq_flag |=> q.scl_stretch_hold && q.addr_stop_irq_flag)
        else $error("hold dropped on clear collision");
    a_drop_tmo: assert property (@(posedge pclk) disable iff (!presetn)
        ln.start && tmo_fire && q.ctrl[2] |=> q.st == tws_pkg::TWS_IDLE && !q.busy)
        else $error("transaction not dropped");
    a_dif_late: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == tws_pkg::CMD_OFS && pwdata[1:0] == 2'h3 && q.dif_clr_pend == 1'b0
        && !ln.fall |=> q.dif_clr_pend ##1 !q.byte_irq_flag)
        else $error("byte flag clear timing wrong");
    a_addr_stop_irq_flag_clr: assert property (@(posedge pclk) disable iff (!presetn)
        sw_clr_addr_stop_irq_flag && !hw_set_addr_stop_irq_flag && !ln.stop |=> !q.addr_stop_irq_flag)
        else $error("addr stop flag not cleared");
    a_hold_release: assert property (@(posedge pclk) disable iff (!presetn)
        sw_clr_addr_stop_irq_flag && !hw_set_addr_stop_irq_flag && q.st == tws_pkg::TWS_ACK && !ln.fall && !ln.start
        && !ln.stop |=> !q.scl_stretch_hold)
        else $error("clock hold kept after flag clear");
    a_addr_stop_irq_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        hw_set_addr_stop_irq_flag |=> q.addr_stop_irq_flag && q.scl_stretch_hold)
        else $error("address match not flagged");
    c_addr: cover property (@(posedge pclk) hw_set_addr_stop_irq_flag);
    c_lock: cover property (@(posedge pclk) hw_set_addr_stop_irq_flag && sw_clr_addr_stop_irq_flag);
    c_drop: cover property (@(posedge pclk) ln.start && tmo_fire);
    c_cmd3: cover property (@(posedge pclk) q.dif_clr_pend);
endmodule // tws_slave

//--- rtl/tws_pkg.sv
package tws_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS     = 8'h00;
    localparam logic [7:0] STATUS_OFS   = 8'h04;
    localparam logic [7:0] CMD_OFS      = 8'h08;
    localparam logic [7:0] TXDATA_OFS   = 8'h0C;
    localparam logic [7:0] RXDATA_OFS   = 8'h10;
    localparam logic [7:0] ADDR_OFS     = 8'h14;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h18;
    localparam logic [7:0] IRQ_EN_OFS   = 8'h1C;
    localparam logic [7:0] IRQ_CLR_OFS  = 8'h20;

    // Control fields
    localparam int CTRL_EN_BIT      = 0;
    localparam int CTRL_TMO_EN_BIT  = 1;
    localparam int CTRL_QUIRK_BIT   = 2;

    // Status fields
    localparam int ST_ASIF_BIT   = 0;
    localparam int ST_BIF_BIT    = 1;
    localparam int ST_COLL_BIT   = 2;
    localparam int ST_HOLD_BIT   = 3;
    localparam int ST_DIR_BIT    = 4;
    localparam int ST_ISADDR_BIT = 5;
    localparam int ST_BUSY_BIT   = 6;

    // Interrupt event bits
    localparam int EV_ADDR_BIT  = 0;
    localparam int EV_STOP_BIT  = 1;
    localparam int EV_BYTE_BIT  = 2;
    localparam int EV_DROP_BIT  = 3;
    localparam int EV_COLL_BIT  = 4;
    localparam int EV_W         = 5;

    // Slave response commands: complete a transaction, or respond with the TX data
    localparam logic [1:0] CMD_RESP_COMPLETE = 2'h3;
    localparam logic [1:0] CMD_RESP_RESPOND  = 2'h2;

    localparam logic [6:0] ADDR_RST      = 7'h50;
    localparam logic [2:0] CTRL_RST      = 3'h1;

    // Bus timeout
    localparam int TMO_NS     = 25000;
    localparam int CLK_NS     = 5;
    localparam int TMO_CYCLES = TMO_NS / CLK_NS;

    typedef enum logic [2:0] {
        TWS_IDLE = 3'b000,
        TWS_ADDR = 3'b001,
        TWS_RX   = 3'b010,
        TWS_TX   = 3'b011,
        TWS_ACK  = 3'b100,
        TWS_SKIP = 3'b101
    } tws_st_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
        logic sda;
    } tws_line_t;

endpackage

//--- rtl/tws_line_mon.sv
`timescale 1ns/10ps
// Edge and condition detector on the synchronous bus lines
module tws_line_mon (
    // Clock and reset
    input  wire logic            pclk,
    input  wire logic            presetn,
    // Bus lines
    input  wire logic            scl_i,
    input  wire logic            sda_i,
    // Events
    output tws_pkg::tws_line_t   ev
);
    typedef struct packed {
        logic scl;
        logic sda;
    } tws_mon_t;

    tws_mon_t s_q;
    tws_mon_t s_d;

    always_comb begin
        s_d.scl = scl_i;
        s_d.sda = sda_i;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    // Lines idle high, so reset values give no false edges
    assign ev.start = s_q.scl & scl_i & s_q.sda & ~sda_i;
    assign ev.stop  = s_q.scl & scl_i & ~s_q.sda & sda_i;
    assign ev.rise  = ~s_q.scl & scl_i;
    assign ev.fall  = s_q.scl & ~scl_i;
    assign ev.sda   = sda_i;
endmodule // tws_line_mon

//--- verif/tws_bus_master.sv
`timescale 1ns/10ps
// Behavioural bus master; lines are only pulled low or released
module tws_bus_master #(
    parameter int HALF = 10
) (
    // Clock
    input  wire logic pclk,
    // Wire levels
    input  wire logic scl,
    input  wire logic sda,
    // Pull-downs
    output logic      scl_low,
    output logic      sda_low
);
    initial begin
        scl_low = 1'h0;
        sda_low = 1'h0;
    end

    task automatic gap();
        repeat (HALF) @(posedge pclk);
    endtask

    // Bounded, so a slave stuck holding SCL shows up as failed checks
    task automatic scl_up();
        int n;
        n = 0;
        scl_low <= 1'h0;
        @(posedge pclk);
        while (scl !== 1'h1 && n < 4000) begin
            @(posedge pclk);
            n++;
        end
    endtask

    // Also serves as repeated start when SCL is low
    task automatic start();
        sda_low <= 1'h0;
        gap();
        scl_up();
        gap();
        sda_low <= 1'h1;
        gap();
        scl_low <= 1'h1;
        gap();
    endtask

    task automatic stop();
        sda_low <= 1'h1;
        gap();
        scl_up();
        gap();
        sda_low <= 1'h0;
        gap();
    endtask

    // One bit on the wire; a 1 releases SDA
    task automatic ack(input logic o, output logic i);
        sda_low <= ~o;
        gap();
        scl_up();
        gap();
        i = sda;
        scl_low <= 1'h1;
        gap();
    endtask

    // Eight data bits, leaving the acknowledge clock to the caller
    task automatic byte8(input logic [7:0] out, output logic [7:0] in);
        for (int i = 7; i >= 0; i--) begin
            ack(out[i], in[i]);
        end
    endtask

    task automatic bits9(input logic [8:0] out, output logic [8:0] in);
        logic [7:0] b;
        logic       a;
        byte8(out[8:1], b);
        ack(out[0], a);
        in = {b, a};
    endtask
endmodule // tws_bus_master

//--- verif/testbench.sv
`timescale 1ns/10ps
module testbench;
    localparam logic [7:0]  ST   = tws_pkg::STATUS_OFS;
    localparam logic [7:0]  CMD  = tws_pkg::CMD_OFS;
    localparam logic [7:0]  ICLR = tws_pkg::IRQ_CLR_OFS;
    localparam logic [7:0]  IEN  = tws_pkg::IRQ_EN_OFS;
    localparam logic [31:0] ASIF = 32'h1 << tws_pkg::ST_ASIF_BIT;
    localparam logic [31:0] BIF  = 32'h1 << tws_pkg::ST_BIF_BIT;
    localparam logic [31:0] COLL = 32'h1 << tws_pkg::ST_COLL_BIT;
    localparam logic [31:0] HOLD = 32'h1 << tws_pkg::ST_HOLD_BIT;
    localparam logic [8:0]  AW   = {tws_pkg::ADDR_RST, 2'h1};
    localparam logic [8:0]  AR   = {tws_pkg::ADDR_RST, 2'h3};
    logic        pclk = 1'h0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic        scl_o, scl_oe, sda_o, sda_oe, m_scl_low, m_sda_low, scl_w, sda_w;
    logic        rd_pend = 1'h0;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [8:0]  got;
    logic [15:0] seed;
    logic [63:0] exp_q[$];
    int          mismatches, total_checks;

    // Open-drain wires with pull-ups
    assign scl_w = !(m_scl_low || (scl_oe && !scl_o));
    assign sda_w = !(m_sda_low || (sda_oe && !sda_o));

    tws_slave #(.TMO_CYC(20)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scl_i(scl_w), .scl_o(scl_o),
        .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));

    tws_bus_master #(.HALF(10)) mst (
        .pclk(pclk), .scl(scl_w), .sda(sda_w), .scl_low(m_scl_low), .sda_low(m_sda_low));

    always #2.5 pclk = ~pclk;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
        total_checks++;
        if (got_v !== exp_v) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got_v, exp_v);
        end
    endtask

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
    endtask

    task automatic rel();
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'h1, d);
        rel();
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back({e, m});
        apb(a, 1'h0, 32'h0);
        rel();
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Read data stands the cycle after the access edge; looked at mid-cycle
    always @(posedge pclk) begin
        rd_pend <= psel && penable && !pwrite && pready;
    end

    always @(negedge pclk) begin
        if (rd_pend && exp_q.size() > 0) begin
            chk(prdata & exp_q[0][31:0], exp_q[0][63:32]);
            void'(exp_q.pop_front());
        end
    end

    initial begin
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        mismatches = 0;
        total_checks = 0;
        seed = 16'h32B3;
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        rd(tws_pkg::CTRL_OFS, {29'h0, tws_pkg::CTRL_RST}, 32'h7);
        rd(tws_pkg::ADDR_OFS, {25'h0, tws_pkg::ADDR_RST}, 32'h7F);
        rd(8'h24, 32'h0, 32'hFFFF_FFFF);
        wr(IEN, 32'h1F);
        wr(tws_pkg::CTRL_OFS, 32'h1);
        // Address write, slave stretches until software clears the flag
        mst.start();
        mst.byte8(AW[8:1], got[8:1]);
        chk({31'h0, scl_oe}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        rd(ST, ASIF | HOLD, ASIF | HOLD);
        wr(ST, 32'h0);
        rd(ST, ASIF, ASIF);
        wr(ST, ASIF);
        @(posedge pclk);
        chk({31'h0, scl_oe}, 32'h0);
        wr(ST, COLL);
        mst.ack(AW[0], got[0]);
        chk({31'h0, got[0]}, 32'h0);
        seed = lfsr(seed);
        mst.byte8(seed[7:0], got[8:1]);
        rd(tws_pkg::RXDATA_OFS, {24'h0, seed[7:0]}, 32'hFF);
        rd(ST, BIF, BIF);
        wr(ICLR, 32'h1F);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        // Complete, then read status back to back; setup cycle is the idle cycle
        apb(CMD, 1'h1, {30'h0, tws_pkg::CMD_RESP_COMPLETE});
        exp_q.push_back({32'h0, BIF});
        apb(ST, 1'h0, 32'h0);
        rel();
        mst.ack(1'h1, got[0]);
        chk({31'h0, got[0]}, 32'h0);
        mst.stop();
        chk({31'h0, irq}, 32'h0);
        rd(ST, 32'h0, ASIF);
        wr(IEN, 32'h0);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        wr(ICLR, 32'h1F);
        wr(IEN, 32'h1F);
        wr(ST, ASIF);
        // Read with the master pulling SDA low against the slave's ones
        mst.start();
        mst.byte8(AR[8:1], got[8:1]);
        wr(tws_pkg::TXDATA_OFS, 32'hFF);
        wr(CMD, {30'h0, tws_pkg::CMD_RESP_RESPOND});
        mst.ack(AR[0], got[0]);
        chk({31'h0, got[0]}, 32'h0);
        mst.bits9(9'h001, got);
        rd(ST, COLL, COLL);
        wr(CMD, {30'h0, tws_pkg::CMD_RESP_COMPLETE});
        mst.start();
        rd(ST, COLL, COLL);
        mst.stop();
        mst.start();
        rd(ST, 32'h0, COLL);
        mst.stop();
        repeat (4) @(posedge pclk);
        close_out();
    end

    initial begin
        repeat (40000) @(posedge pclk);
        mismatches++;
        close_out();
    end
endmodule // testbench
